// *** rtl/tbo_defs.svh ***
// timing, width and count constants of the touch button output block
`ifndef TBO_DEFS_SVH
`define TBO_DEFS_SVH
// ----------------------------------------------------------------
// clock and time base
// ----------------------------------------------------------------
`define TBO_CLK_PERIOD_NS 4
`define TBO_MS_NS 1000000
`define TBO_NCH 4
// ----------------------------------------------------------------
// self test timing, in ms
// ----------------------------------------------------------------
`define TBO_POWER_ON_SELF_TEST_MS 175
`define TBO_PULSE_MS 5
`define TBO_POWER_ON_SELF_TEST_W 8
// ----------------------------------------------------------------
// hold-on interval, in ms and steps
// ----------------------------------------------------------------
`define TBO_HOLD_STEP_MS 20
`define TBO_HOLD_MAX_STEPS 100
`define TBO_HOLD_W 12
// ----------------------------------------------------------------
// auto release, in ms
// ----------------------------------------------------------------
`define TBO_AR_SHORT_MS 5000
`define TBO_AR_LONG_MS 20000
`define TBO_AR_SPLIT_MS 2000
`define TBO_AR_QUICK_HOLD_MS 220
`define TBO_AR_EXTRA_MS 200
`define TBO_AR_W 15
// ----------------------------------------------------------------
// strap bit positions
// ----------------------------------------------------------------
`define TBO_TS_TOGGLE 0
`define TBO_TS_FLANK 1
`define TBO_AR_EN 0
`define TBO_AR_LONG 1
`endif

// *** rtl/tbo_pkg.sv ***
// types of the touch button output block
package tbo_pkg;
   // self test phase after reset, one-hot
   typedef enum logic [2:0] {
      TBO_PH_WAIT  = 3'b001,
      TBO_PH_PULSE = 3'b010,
      TBO_PH_RUN   = 3'b100
   } tbo_phase_t;
endpackage

// *** rtl/tbo_top.sv ***
// output and feature logic of a four channel touch button controller
//
// Behaviour
// - each output follows its own channel, active low
// - failed channel: 5 ms low pulse by 175 ms
// - deep sleep drives all outputs high
// - low-power sleep holds previous output levels
// - any reset puts outputs in high impedance
// - toggle mode: each new touch inverts output
// - flanking: single touched button is reported
// - flanking: of several, earlier touched one wins
// - hold-on keeps output low after release
// - no hold-on after auto release
// - another button's release cancels pending hold-on
// - hold-on 0 to 2000 ms, 20 ms steps
// - auto release ends over-long continuous touch
// - auto release period 5 or 20 s, strap
// - power_on_self_test-release block 220 ms or scan+200 ms
// - channel shorted to ground or supply disabled
// - channels shorted together all disabled
// - bad modulator capacitor disables all channels
// - parasitic capacitance over 40 pF disables channel
// - straps sampled once after each reset release
`timescale 1ns/1ns
`include "tbo_defs.svh"

module tbo_top
   import tbo_pkg::*;
#(
   parameter int MS_CYC = `TBO_MS_NS / `TBO_CLK_PERIOD_NS
) (
   input wire logic ref_clk, // 250 MHz system clock
   input wire logic rst_b, // power-on reset, active low
   input wire logic external_reset_pin, // external reset, active high
   input wire logic [3:0] touch_input, // touch flags from front end
   input wire logic scan_strobe, // one pulse per scan interval
   input wire logic [1:0] toggle_suppress_strap, // toggle, flanking
   input wire logic [1:0] auto_release_strap, // enable, 20 s select
   input wire logic [6:0] hold_on_interval, // hold-on in 20 ms steps
   input wire logic [9:0] scan_interval_sleep_strap, // scan ms
   input wire logic deep_sleep, // deep sleep request
   input wire logic low_power_sleep, // low-power sleep request
   input wire logic [3:0] short_gnd, // test: shorted to ground
   input wire logic [3:0] short_vdd, // test: shorted to supply
   input wire logic [3:0] short_pair, // test: shorted to another
   input wire logic modulator_cap_low, // test: below 1 nF
   input wire logic modulator_cap_high, // test: above 4 nF
   input wire logic [3:0] parasitic_cap_high, // test: over 40 pF
   output logic [3:0] button_output, // output level, low active
   output logic [3:0] button_output_oe_b, // low while driving
   output logic [3:0] channel_failed // self test result
);

   // ----------------------------------------------------------------
   // reset and millisecond time base
   // ----------------------------------------------------------------
   // both resets act alike; outputs float while either is held
   wire rst_ok = rst_b & ~external_reset_pin;

   logic [31:0] div_ff;
   logic ms_tick_ff;
   wire div_end = (div_ff == 32'(MS_CYC - 1));

   // divider gives one enable pulse per ms
   always_ff @(posedge ref_clk) begin
      if (!rst_ok) begin
         div_ff <= 32'h0;
         ms_tick_ff <= 1'b0;
      end else begin
         div_ff <= div_end ? 32'h0 : div_ff + 32'h1;
         ms_tick_ff <= div_end;
      end
   end

   // ----------------------------------------------------------------
   // strap capture
   // ----------------------------------------------------------------
   logic cfg_taken_ff;
   logic tog_en_ff;
   logic flank_en_ff;
   logic ar_en_ff;
   logic ar_long_ff;
   logic [6:0] hold_steps_ff;
   logic [9:0] scan_ms_ff;

   // straps read once after release; later changes are ignored
   always_ff @(posedge ref_clk) begin
      if (!rst_ok) begin
         cfg_taken_ff <= 1'b0;
         tog_en_ff <= 1'b0;
         flank_en_ff <= 1'b0;
         ar_en_ff <= 1'b0;
         ar_long_ff <= 1'b0;
         hold_steps_ff <= 7'h0;
         scan_ms_ff <= 10'h0;
      end else if (!cfg_taken_ff) begin
         cfg_taken_ff <= 1'b1;
         tog_en_ff <= toggle_suppress_strap[`TBO_TS_TOGGLE];
         flank_en_ff <= toggle_suppress_strap[`TBO_TS_FLANK];
         ar_en_ff <= auto_release_strap[`TBO_AR_EN];
         ar_long_ff <= auto_release_strap[`TBO_AR_LONG];
         hold_steps_ff <= hold_on_interval;
         scan_ms_ff <= scan_interval_sleep_strap;
      end
   end

   // hold-on length, clamped to the 2 s ceiling
   wire [6:0] hold_steps_c = (hold_steps_ff > 7'(`TBO_HOLD_MAX_STEPS)) ?
      7'(`TBO_HOLD_MAX_STEPS) : hold_steps_ff;
   wire [11:0] hold_ms = 12'(hold_steps_c) *
      12'(`TBO_HOLD_STEP_MS);
   wire [14:0] ar_period = ar_long_ff ? 15'(`TBO_AR_LONG_MS) :
      15'(`TBO_AR_SHORT_MS);
   wire [11:0] blk_long = 12'(scan_ms_ff) + 12'(`TBO_AR_EXTRA_MS);

   // ----------------------------------------------------------------
   // self test sequencing
   // ----------------------------------------------------------------
   tbo_phase_t phase_ff;
   tbo_phase_t nxt_phase;
   logic [7:0] power_on_self_test_ms_ff;
   logic [3:0] fail_ff;

   wire [7:0] pulse_at = 8'(`TBO_POWER_ON_SELF_TEST_MS - `TBO_PULSE_MS);
   wire [7:0] power_on_self_test_end = 8'(`TBO_POWER_ON_SELF_TEST_MS);
   wire cap_bad = modulator_cap_low | modulator_cap_high;
   // faults sampled at pulse start; the front end settles by then
   wire [3:0] fault_now = short_gnd | short_vdd
      | short_pair
      | parasitic_cap_high
      | {4{cap_bad}};

   // pulse sits at the tail of the window so it ends by 175 ms
   always_comb begin
      nxt_phase = phase_ff;
      unique case (phase_ff)
         TBO_PH_WAIT: begin
            if (ms_tick_ff && power_on_self_test_ms_ff == pulse_at - 8'h1) begin
               nxt_phase = TBO_PH_PULSE;
            end
         end
         TBO_PH_PULSE: begin
            if (ms_tick_ff && power_on_self_test_ms_ff == power_on_self_test_end - 8'h1) begin
               nxt_phase = TBO_PH_RUN;
            end
         end
         TBO_PH_RUN: begin
            nxt_phase = TBO_PH_RUN;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_ok) begin
         phase_ff <= TBO_PH_WAIT;
         power_on_self_test_ms_ff <= 8'h0;
         fail_ff <= 4'h0;
      end else begin
         phase_ff <= nxt_phase;
         if (ms_tick_ff && phase_ff != TBO_PH_RUN) begin
            power_on_self_test_ms_ff <= power_on_self_test_ms_ff + 8'h1;
         end
         if (phase_ff == TBO_PH_WAIT && nxt_phase == TBO_PH_PULSE) begin
            fail_ff <= fault_now;
         end
      end
   end

   wire run = (phase_ff == TBO_PH_RUN);
   assign channel_failed = fail_ff;

   // ----------------------------------------------------------------
   // flanking suppression over the per-scan touch flags
   // ----------------------------------------------------------------
   logic [3:0] rep_ff;
   logic [3:0] stuck_ff;
   logic [3:0] blk_act;
   logic [3:0] hold_act;
   logic [3:0] tog_ff;

   // disabled, blocked or auto-released channels see no touch
   wire [3:0] raw = touch_input & ~fail_ff & ~blk_act & ~stuck_ff
      & {4{run}};
   wire multi = (raw & (raw - 4'h1)) != 4'h0;
   wire [3:0] keep = raw & rep_ff;
   // several new touches with no earlier one report nothing
   wire [3:0] sel = !flank_en_ff ? raw :
      (!multi ? raw : keep);
   wire [3:0] rise = {4{scan_strobe}} & sel & ~rep_ff;
   wire [3:0] fall = {4{scan_strobe}} & ~sel & rep_ff;

   // ----------------------------------------------------------------
   // per channel hold, auto release and toggle
   // ----------------------------------------------------------------
   for (genvar i = 0; i < `TBO_NCH; i++) begin : g_ch
      logic [14:0] ar_cnt_ff;
      logic [11:0] hold_cnt_ff;
      logic [11:0] blk_cnt_ff;
      wire other_fall = (fall & ~(4'h1 << i)) != 4'h0;
      wire ar_hit = ar_en_ff && rep_ff[i] && !stuck_ff[i]
         && ar_cnt_ff == ar_period - 15'h1;
      wire split = ar_cnt_ff >= 15'(`TBO_AR_SPLIT_MS);
      wire let_go = scan_strobe && stuck_ff[i] && !touch_input[i];

      assign hold_act[i] = hold_cnt_ff != 12'h0;
      assign blk_act[i] = blk_cnt_ff != 12'h0;

      // reported state follows the scan; auto release drops it now
      always_ff @(posedge ref_clk) begin
         if (!rst_ok) begin
            rep_ff[i] <= 1'b0;
            tog_ff[i] <= 1'b0;
         end else begin
            if (ms_tick_ff && ar_hit) begin
               rep_ff[i] <= 1'b0;
            end else if (scan_strobe) begin
               rep_ff[i] <= sel[i];
            end
            if (rise[i]) begin
               tog_ff[i] <= ~tog_ff[i];
            end
         end
      end

      // touch time, then time still touched after auto release
      always_ff @(posedge ref_clk) begin
         if (!rst_ok) begin
            ar_cnt_ff <= 15'h0;
            stuck_ff[i] <= 1'b0;
         end else if (let_go) begin
            ar_cnt_ff <= 15'h0;
            stuck_ff[i] <= 1'b0;
         end else if (ms_tick_ff && ar_hit) begin
            ar_cnt_ff <= 15'h0;
            stuck_ff[i] <= 1'b1;
         end else if (rise[i] || (!rep_ff[i] && !stuck_ff[i])) begin
            ar_cnt_ff <= 15'h0;
         end else if (ms_tick_ff && (rep_ff[i] || !split)) begin
            ar_cnt_ff <= ar_cnt_ff + 15'h1;
         end
      end

      // block after letting go of an auto-released button
      always_ff @(posedge ref_clk) begin
         if (!rst_ok) begin
            blk_cnt_ff <= 12'h0;
         end else if (let_go) begin
            blk_cnt_ff <= split ? blk_long :
               12'(`TBO_AR_QUICK_HOLD_MS);
         end else if (ms_tick_ff && blk_act[i]) begin
            blk_cnt_ff <= blk_cnt_ff - 12'h1;
         end
      end

      // hold-on after a normal release; a release elsewhere cancels it
      always_ff @(posedge ref_clk) begin
         if (!rst_ok) begin
            hold_cnt_ff <= 12'h0;
         end else if (fall[i] && !stuck_ff[i]) begin
            hold_cnt_ff <= hold_ms;
         end else if (rise[i] || (fall[i] && stuck_ff[i])) begin
            hold_cnt_ff <= 12'h0;
         end else if (other_fall) begin
            hold_cnt_ff <= 12'h0;
         end else if (ms_tick_ff && hold_act[i]) begin
            hold_cnt_ff <= hold_cnt_ff - 12'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // output drive
   // ----------------------------------------------------------------
   wire [3:0] act = tog_en_ff ? tog_ff : (rep_ff | hold_act);
   wire pulse = (phase_ff == TBO_PH_PULSE);
   logic [3:0] out_ff;
   logic [3:0] nxt_out;
   logic drive_ff;

   // priority: deep sleep, low-power freeze, self test, normal
   always_comb begin
      if (deep_sleep) begin
         nxt_out = 4'hf;
      end else if (low_power_sleep) begin
         nxt_out = out_ff;
      end else if (pulse) begin
         nxt_out = ~fail_ff;
      end else if (!run) begin
         nxt_out = 4'hf;
      end else begin
         nxt_out = ~act | fail_ff;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_ok) begin
         out_ff <= 4'hf;
         drive_ff <= 1'b0;
      end else begin
         out_ff <= nxt_out;
         drive_ff <= 1'b1;
      end
   end

   assign button_output = out_ff;
   assign button_output_oe_b = {4{~drive_ff}};

endmodule

// *** tb/tbo_top_chk.sv ***
// assertion checker bound to the touch button output block
`timescale 1ns/1ns
module tbo_top_chk #(
   parameter int MS_CYC = 250000
) (
   input wire logic ref_clk, // clock
   input wire logic rst_b, // power-on reset
   input wire logic external_reset_pin, // external reset
   input wire logic [3:0] touch_input, // touch flags
   input wire logic scan_strobe, // scan pulse
   input wire logic [1:0] toggle_suppress_strap, // toggle, flanking
   input wire logic [1:0] auto_release_strap, // auto release
   input wire logic [6:0] hold_on_interval, // hold-on steps
   input wire logic deep_sleep, // deep sleep
   input wire logic low_power_sleep, // low-power sleep
   input wire logic [3:0] button_output, // output level
   input wire logic [3:0] button_output_oe_b, // output enable
   input wire logic [3:0] channel_failed // self test result
);
   // ------------
   // time base
   // ------------
   // count saturates, so a long run never wraps into the test window
   wire rst_any = !rst_b || external_reset_pin;
   wire slp = deep_sleep || low_power_sleep;
   logic [31:0] cnt_ff;
   logic plain_ff;
   wire [31:0] nxt_cnt = rst_any ? 32'h0 : cnt_ff + {31'h0, ~&cnt_ff};
   wire nxt_plain = {toggle_suppress_strap, auto_release_strap,
      hold_on_interval} == 11'h0;
   wire run = cnt_ff > 32'(176 * MS_CYC);
   // straps taken once at the first edge after release
   always_ff @(posedge ref_clk) begin
      cnt_ff <= nxt_cnt;
      if (!rst_any && cnt_ff == 32'h0) plain_ff <= nxt_plain;
   end
   // ------------
   // properties
   // ------------
   default clocking cb @(posedge ref_clk);
   endclocking
   sequence s_plain_scan;
      run && plain_ff && scan_strobe;
   endsequence
   sequence s_awake;
      !slp ##1 !slp ##1 !slp;
   endsequence
   chk_reset_hiz: assert property (
      rst_any |=> button_output_oe_b == 4'hf)
      else $error("outputs driven during reset");
   chk_drive_on: assert property (disable iff (rst_any)
      !rst_any |=> button_output_oe_b == 4'h0)
      else $error("outputs not driven after release");
   chk_deep_high: assert property (disable iff (rst_any)
      deep_sleep |=> button_output == 4'hf)
      else $error("output low in deep sleep");
   chk_lp_freeze: assert property (disable iff (rst_any)
      low_power_sleep && !deep_sleep |=> $stable(button_output))
      else $error("output moved in low-power sleep");
   chk_quiet_start: assert property (disable iff (rst_any)
      cnt_ff < 32'(169 * MS_CYC) |-> button_output == 4'hf)
      else $error("output low before self test pulse");
   chk_pulse_low: assert property (disable iff (rst_any)
      cnt_ff == 32'(173 * MS_CYC) && !$past(slp)
      |-> (button_output & channel_failed) == 4'h0)
      else $error("failed channel not pulsed");
   chk_fail_steady: assert property (disable iff (rst_any)
      cnt_ff > 32'(171 * MS_CYC) |=> $stable(channel_failed))
      else $error("failed set changed after self test");
   chk_fail_high: assert property (disable iff (rst_any)
      run && !$past(slp)
      |-> (button_output & channel_failed) == channel_failed)
      else $error("failed channel output low");
   chk_scan_follow: assert property (disable iff (rst_any)
      s_plain_scan ##0 s_awake
      |-> button_output == ~($past(touch_input, 2) & ~channel_failed))
      else $error("output does not follow scan");
endmodule

bind tbo_top tbo_top_chk #(.MS_CYC(MS_CYC)) u_chk (.ref_clk(ref_clk),
   .rst_b(rst_b), .external_reset_pin(external_reset_pin),
   .touch_input(touch_input), .scan_strobe(scan_strobe),
   .toggle_suppress_strap(toggle_suppress_strap),
   .auto_release_strap(auto_release_strap),
   .hold_on_interval(hold_on_interval), .deep_sleep(deep_sleep),
   .low_power_sleep(low_power_sleep), .button_output(button_output),
   .button_output_oe_b(button_output_oe_b),
   .channel_failed(channel_failed));

// *** tb/tbo_led_model.sv ***
// led load on the button outputs, with pull-up and low-time counters
`timescale 1ns/1ns
module tbo_led_model (
   input wire logic ref_clk, // clock
   input wire logic [3:0] button_output, // level from the block
   input wire logic [3:0] button_output_oe_b, // low while driven
   output logic [3:0] pin_level, // resolved pin level
   output int low_cyc [4] // low cycles since last release
);
   // a released pin is pulled up through the led resistor
   assign pin_level = button_output | button_output_oe_b;
   // counters restart while every pin is released
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < 4; i++) begin
         if (&button_output_oe_b) low_cyc[i] <= 0;
         else if (!pin_level[i]) low_cyc[i] <= low_cyc[i] + 1;
      end
   end
endmodule

// *** tb/tbo_top_tb_top.sv ***
// self-checking bench for the touch button output block
`timescale 1ns/1ns
module tbo_top_tb_top;
   import tbo_pkg::*;
   localparam int MS = 4; // cycles per ms, keeps the run short
   logic ref_clk = 0, rst_b = 0, ext = 0, scan = 0, deep = 0, lps = 0;
   logic mlo = 0, mhi = 0;
   logic [1:0] tog = 0, ar = 0;
   logic [6:0] hold = 0;
   logic [3:0] touch = 0, sg = 0, sv = 0, sp = 0, pc = 0;
   logic [3:0] bo, oe_b, failed, pin;
   int low_cyc [4];
   int n_mismatch = 0, compares = 0;
   // fault sets {mod low, mod high, cp, pair, vdd, gnd}
   logic [17:0] ftab [4] = '{18'h20000, 18'h10000, 18'h00610, 18'h08004};
   tbo_top #(.MS_CYC(MS)) u_dut (.ref_clk(ref_clk), .rst_b(rst_b),
      .external_reset_pin(ext), .touch_input(touch), .scan_strobe(scan),
      .toggle_suppress_strap(tog), .auto_release_strap(ar),
      .hold_on_interval(hold), .scan_interval_sleep_strap(10'h014),
      .deep_sleep(deep), .low_power_sleep(lps), .short_gnd(sg),
      .short_vdd(sv), .short_pair(sp), .modulator_cap_low(mlo),
      .modulator_cap_high(mhi), .parasitic_cap_high(pc),
      .button_output(bo), .button_output_oe_b(oe_b),
      .channel_failed(failed));
   tbo_led_model u_led (.ref_clk(ref_clk), .button_output(bo),
      .button_output_oe_b(oe_b), .pin_level(pin), .low_cyc(low_cyc));
   initial forever #2 ref_clk = ~ref_clk;
   // ------------
   // helpers
   // ------------
   function automatic logic [3:0] exp_fail(logic [17:0] f);
      return f[15:12] | f[11:8] | f[7:4] | f[3:0] | {4{|f[17:16]}};
   endfunction
   task automatic cyc(int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic check(string what, logic [3:0] seen, logic [3:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   // one scan pulse; output is settled two edges after it is taken
   task automatic step(string what, logic [3:0] t, logic [3:0] e);
      @(posedge ref_clk);
      scan <= 1'b1;
      touch <= t;
      @(posedge ref_clk);
      scan <= 1'b0;
      cyc(2);
      check(what, bo, e);
   endtask
   // reset, straps and faults held through the self test
   task automatic restart(logic x, logic [1:0] t, logic [1:0] a,
      logic [6:0] h, logic [17:0] f);
      logic [3:0] e, pl;
      @(posedge ref_clk);
      ext <= x;
      rst_b <= x;
      {tog, ar, hold, mlo, mhi, pc, sp, sv, sg} <= {t, a, h, f};
      cyc(10);
      check("oe_b in reset", oe_b, 4'hf);
      check("pin in reset", pin, 4'hf);
      @(posedge ref_clk);
      ext <= 1'b0;
      rst_b <= 1'b1;
      cyc(180 * MS);
      e = exp_fail(f);
      for (int i = 0; i < 4; i++) pl[i] = low_cyc[i] == (e[i] ? 5 * MS : 0);
      check("oe_b driven", oe_b, 4'h0);
      check("failed", failed, e);
      check("pulse", pl, 4'hf);
   endtask
   task automatic complete_run();
      $display("compares %0d, mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ------------
   // scenarios
   // ------------
   initial begin
      logic [3:0] v;
      void'($urandom(23));
      for (int r = 0; r < 4; r++) begin
         restart(r[0], 2'b00, 2'b00, 7'h00, ftab[r]);
         repeat (20) begin
            v = 4'($urandom);
            step("plain", v, ~(v & ~exp_fail(ftab[r])));
         end
      end
      // sleep modes with channels 2 and 3 failed
      step("live", 4'h1, 4'he);
      @(posedge ref_clk);
      deep <= 1'b1;
      step("deep", 4'h2, 4'hf);
      @(posedge ref_clk);
      deep <= 1'b0;
      step("wake", 4'h2, 4'hd);
      @(posedge ref_clk);
      lps <= 1'b1;
      step("lp hold", 4'h1, 4'hd);
      @(posedge ref_clk);
      lps <= 1'b0;
      restart(1'b1, 2'b01, 2'b00, 7'h00, 18'h0);
      step("tgl on", 4'h1, 4'he);
      step("tgl keep", 4'h0, 4'he);
      step("tgl off", 4'h1, 4'hf);
      step("tgl idle", 4'h0, 4'hf);
      // flanking with no faults; the earlier touch on channel 1 wins over channel 2
      restart(1'b0, 2'b10, 2'b00, 7'h00, 18'h0);
      step("fss one", 4'h2, 4'hd);
      step("fss prior", 4'h6, 4'hd);
      step("fss none", 4'h0, 4'hf);
      step("fss tie", 4'h6, 4'hf);
      step("fss new", 4'h4, 4'hb);
      restart(1'b1, 2'b00, 2'b00, 7'h02, 18'h0);
      step("hold on", 4'h1, 4'he);
      step("hold rel", 4'h0, 4'he);
      cyc(30 * MS);
      check("hold mid", bo, 4'he);
      cyc(15 * MS);
      check("hold end", bo, 4'hf);
      step("hold a", 4'h1, 4'he);
      step("hold b", 4'h0, 4'he);
      step("other on", 4'h2, 4'hc);
      step("other rel", 4'h0, 4'hd);
      restart(1'b0, 2'b00, 2'b01, 7'h02, 18'h0);
      step("ar on", 4'h1, 4'he);
      cyc(4990 * MS);
      check("ar before", bo, 4'he);
      cyc(20 * MS);
      check("ar after", bo, 4'hf);
      step("ar rel", 4'h0, 4'hf);
      cyc(100 * MS);
      step("ar block", 4'h1, 4'hf);
      cyc(160 * MS);
      step("ar again", 4'h1, 4'he);
      complete_run();
   end
   // watchdog: whole plan needs about 27500 cycles
   initial begin
      cyc(60000);
      n_mismatch++;
      $display("unexpected run length: expected end, seen timeout");
      complete_run();
   end
endmodule
